// File: cc_detector_model.sv
// Purpose: behavioural detector feeding asynchronous attach, orientation and advertisement codes
// Assumes: codes change only on its own 200 ns link clock, unrelated to ref_clk
// Notes: each value is held until the next drive call, far longer than the synchroniser needs
`timescale 1ns/1ps
`default_nettype none
module cc_detector_model
(
	// detector results
	output var logic [1:0] det_rp_adv,
	output var logic [2:0] det_attach,
	output var logic [1:0] det_orient
);
	logic link_clk;
	initial
	begin
		link_clk = 1'b0;
		det_rp_adv = 2'h0;
		det_attach = 3'h0;
		det_orient = 2'h0;
		#37;
		forever #100 link_clk = ~link_clk;
	end
	// codes move together on one link edge so no half-updated pair is seen
	task automatic drive(input logic [1:0] rp, input logic [2:0] att, input logic [1:0] ori);
		@(posedge link_clk);
		det_rp_adv = rp;
		det_attach = att;
		det_orient = ori;
	endtask
endmodule
`default_nettype wire

// File: cc_event_interrupt_regs.sv
// Purpose: event mask, sticky event status and attachment status of the configuration-channel detector
// Assumes: detector results arrive asynchronously and are synchronised here; register port is on ref_clk
// Notes: a status read returns the value and clears it on the same edge
//
// Overview of operation
// - mask bit 4 gates the advertisement-change interrupt
// - mask bit 3 gates the role-change interrupt
// - mask bit 2 gates the orientation-found interrupt
// - mask bit 1 gates the debug-accessory interrupt
// - mask bit 0 gates the audio-accessory interrupt
// - mask 1 suppresses, 0 passes; bits 4..0 reset to 1, 7..5 are zero
// - as sink, advertisement change sets status bit 4 and updates attach bits 6..5
// - role change sets status bit 3 and updates attach bits 4..2
// - orientation found sets status bit 2 and updates attach bits 1..0
// - debug accessory sets status bit 1, attach field becomes 100
// - audio accessory sets status bit 0, attach field becomes 011
// - all status bits reset to 0, reserved bits too
// - attachment codes 000 none, 001 source, 010 sink, 011 audio, 100 debug
// - orientation codes 00 none, 01 normal, 10 reversed
`timescale 1ns/1ps
`default_nettype none
module cc_event_interrupt_regs
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// detector results, asynchronous
	input wire logic [1:0] det_rp_adv,
	input wire logic [2:0] det_attach,
	input wire logic [1:0] det_orient,
	// register port from the serial slave
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// state towards the pins and the rest of the chip
	output logic [7:0] attach_status,
	output logic [7:0] event_mask,
	output logic [7:0] event_status,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic [6:0] sync_meta;
	logic [6:0] sync_det;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync_meta <= 7'h00;
			sync_det <= 7'h00;
		end
		else
		begin
			sync_meta <= {det_rp_adv, det_attach, det_orient};
			sync_det <= sync_meta;
		end
	end

	// multi-bit fields may land one cycle apart; a settle stage waits until they agree
	logic [6:0] settled;
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			settled <= 7'h00;
		else
			settled <= sync_det;
	end

	wire stable = (settled == sync_det);
	wire [1:0] new_rp = settled[6:5];
	wire [2:0] new_att = settled[4:2];
	wire [1:0] new_ori = settled[1:0];

	////////////////////////////////////////////////////////////////////////////
	// event detection

	wire [1:0] cur_rp = attach_status[6:5];
	wire [2:0] cur_att = attach_status[4:2];
	wire [1:0] cur_ori = attach_status[1:0];

	// reserved codes are dropped rather than published
	wire att_legal = (new_att <= cc_event_pkg::ATT_DEBUG);
	wire ori_legal = (new_ori != 2'h3);
	wire att_changed = stable && att_legal && (new_att != cur_att);
	wire ori_changed = stable && ori_legal && (new_ori != cur_ori);
	wire rp_changed = stable && (new_rp != cur_rp);

	wire ev_rp = rp_changed && (new_att == cc_event_pkg::ATT_SINK)
		&& (cur_att == cc_event_pkg::ATT_SINK);
	wire ev_role = att_changed;
	wire ev_orient = ori_changed && (new_ori != cc_event_pkg::ORI_NONE);
	wire ev_debug = att_changed && (new_att == cc_event_pkg::ATT_DEBUG);
	wire ev_audio = att_changed && (new_att == cc_event_pkg::ATT_AUDIO);

	wire [4:0] events = {ev_rp, ev_role, ev_orient, ev_debug, ev_audio};

	wire [7:0] next_attach = {1'b0,
		stable ? new_rp : cur_rp,
		att_changed ? new_att : cur_att,
		ori_changed ? new_ori : cur_ori};

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			attach_status <= cc_event_pkg::RST_ATTACH;
		else
			attach_status <= next_attach;
	end

	////////////////////////////////////////////////////////////////////////////
	// register decode

	wire hit_mask = (reg_addr == cc_event_pkg::OFS_MASK);
	wire hit_status = (reg_addr == cc_event_pkg::OFS_STATUS);
	wire wr_mask = reg_wr && hit_mask;
	wire rd_status = reg_rd && hit_status;

	// writes to the reserved block and to status are ignored
	wire [7:0] next_mask = wr_mask ? {3'h0, reg_wdata[4:0]} : event_mask;

	// set wins over the read clear so an event in the read cycle survives
	wire [7:0] next_status = {3'h0,
		(rd_status ? 5'h00 : event_status[4:0]) | events};

	logic [7:0] read_mux;
	always_comb
	begin
		unique case (reg_addr)
			cc_event_pkg::OFS_ATTACH: read_mux = attach_status;
			cc_event_pkg::OFS_RSVD_A: read_mux = cc_event_pkg::RST_RSVD_A;
			cc_event_pkg::OFS_RSVD_B: read_mux = cc_event_pkg::RST_RSVD_B;
			cc_event_pkg::OFS_RSVD_C: read_mux = cc_event_pkg::RST_RSVD_C;
			cc_event_pkg::OFS_RSVD_D: read_mux = cc_event_pkg::RST_RSVD_D;
			cc_event_pkg::OFS_MASK: read_mux = event_mask;
			cc_event_pkg::OFS_STATUS: read_mux = event_status;
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			event_mask <= cc_event_pkg::RST_MASK;
			event_status <= cc_event_pkg::RST_STATUS;
			reg_rdata <= 8'h00;
		end
		else
		begin
			event_mask <= next_mask;
			event_status <= next_status;
			if (reg_rd)
				reg_rdata <= read_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt request

	// mask 1 blocks, 0 passes
	assign irq = |(event_status[4:0] & ~event_mask[4:0]);

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_status_read;
		reg_rd && hit_status;
	endsequence

	sequence s_no_new_event;
		events == 5'h00;
	endsequence

	a_irq_mask_gate: assert property (irq == |(event_status[4:0] & ~event_mask[4:0]))
		else $error("irq does not follow unmasked status");

	a_rp_mask_block: assert property (event_mask[4] && event_status[4:0] == 5'h10 |-> !irq)
		else $error("masked advertisement event raised irq");

	a_role_passes: assert property (!event_mask[3] && event_status[3] |-> irq)
		else $error("unmasked role event did not raise irq");

	a_orient_passes: assert property (!event_mask[2] && event_status[2] |-> irq)
		else $error("unmasked orientation event did not raise irq");

	a_debug_passes: assert property (!event_mask[1] && event_status[1] |-> irq)
		else $error("unmasked debug event did not raise irq");

	a_audio_passes: assert property (!event_mask[0] && event_status[0] |-> irq)
		else $error("unmasked audio event did not raise irq");

	a_mask_write_lands: assert property (reg_wr && hit_mask |=> event_mask == {3'h0, $past(reg_wdata[4:0])})
		else $error("mask write not stored");

	a_read_clears: assert property (s_status_read ##0 s_no_new_event |=> event_status == 8'h00)
		else $error("status not cleared by read");

	a_read_returns: assert property (s_status_read |=> reg_rdata == $past(event_status))
		else $error("status read returned wrong value");

	a_status_sticky: assert property (event_status[4:0] != 5'h00 && !rd_status |=> event_status[4:0] != 5'h00)
		else $error("status bit dropped without read");

	a_debug_code: assert property (ev_debug |=> event_status[1] && attach_status[4:2] == 3'h4)
		else $error("debug event without debug code");

	a_audio_code: assert property (ev_audio |=> event_status[0] && attach_status[4:2] == 3'h3)
		else $error("audio event without audio code");

	a_role_field: assert property (ev_role |=> event_status[3] && attach_status[4:2] == $past(new_att))
		else $error("role event without new role");

	a_orient_field: assert property (ev_orient |=> event_status[2] && attach_status[1:0] == $past(new_ori))
		else $error("orientation event without new orientation");

	a_rp_field: assert property (ev_rp |=> event_status[4] && attach_status[6:5] == $past(new_rp))
		else $error("advertisement event without new advertisement");

	a_reserved_zero: assert property (event_status[7:5] == 3'h0 && event_mask[7:5] == 3'h0)
		else $error("reserved bits not zero");

	////////////////////////////////////////////////////////////////////////////
	// register port and field checks

	sequence s_mask_write;
		reg_wr && hit_mask;
	endsequence

	sequence s_event_fired;
		events != 5'h00;
	endsequence

	// the reserved block must read back its fixed contents however often it is read
	a_rsvd_a_read: assert property (reg_rd && reg_addr == cc_event_pkg::OFS_RSVD_A
		|=> reg_rdata == cc_event_pkg::RST_RSVD_A)
		else $error("reserved register a read wrong");

	a_rsvd_b_read: assert property (reg_rd && reg_addr == cc_event_pkg::OFS_RSVD_B
		|=> reg_rdata == cc_event_pkg::RST_RSVD_B)
		else $error("reserved register b read wrong");

	a_rsvd_c_read: assert property (reg_rd && reg_addr == cc_event_pkg::OFS_RSVD_C
		|=> reg_rdata == cc_event_pkg::RST_RSVD_C)
		else $error("reserved register c read wrong");

	a_rsvd_d_read: assert property (reg_rd && reg_addr == cc_event_pkg::OFS_RSVD_D
		|=> reg_rdata == cc_event_pkg::RST_RSVD_D)
		else $error("reserved register d read wrong");

	a_mask_read: assert property (reg_rd && hit_mask |=> reg_rdata == $past(event_mask))
		else $error("mask read returned wrong value");

	a_attach_read: assert property (reg_rd && reg_addr == cc_event_pkg::OFS_ATTACH
		|=> reg_rdata == $past(attach_status))
		else $error("attachment read returned wrong value");

	a_mask_hold: assert property (not s_mask_write |=> $stable(event_mask))
		else $error("mask changed without a write");

	a_status_no_write: assert property (reg_wr && hit_status && !reg_rd
		|=> event_status[4:0] == ($past(event_status[4:0]) | $past(events)))
		else $error("status write was not ignored");

	a_event_sets: assert property (s_event_fired |=> (event_status[4:0] & $past(events)) == $past(events))
		else $error("fired event not recorded in status");

	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	a_attach_legal: assert property (attach_status[4:2] <= cc_event_pkg::ATT_DEBUG)
		else $error("reserved attachment code published");

	a_orient_legal: assert property (attach_status[1:0] != 2'h3)
		else $error("reserved orientation code published");

	a_attach_top_zero: assert property (attach_status[7] == 1'b0)
		else $error("attachment status top bit set");

	a_attach_holds: assert property (!stable |=> $stable(attach_status))
		else $error("attachment changed on unsettled input");

	a_rp_needs_sink: assert property (ev_rp |-> cur_att == cc_event_pkg::ATT_SINK)
		else $error("advertisement event outside sink attachment");

	a_orient_nonzero: assert property (ev_orient |=> attach_status[1:0] != cc_event_pkg::ORI_NONE)
		else $error("orientation event with no orientation");

	a_rp_passes: assert property (!event_mask[4] && event_status[4] |-> irq)
		else $error("unmasked advertisement event did not raise irq");

	a_role_mask_block: assert property (event_mask[3] && event_status[4:0] == 5'h08 |-> !irq)
		else $error("masked role event raised irq");

	a_orient_mask_block: assert property (event_mask[2] && event_status[4:0] == 5'h04 |-> !irq)
		else $error("masked orientation event raised irq");

	a_debug_mask_block: assert property (event_mask[1] && event_status[4:0] == 5'h02 |-> !irq)
		else $error("masked debug event raised irq");

	a_audio_mask_block: assert property (event_mask[0] && event_status[4:0] == 5'h01 |-> !irq)
		else $error("masked audio event raised irq");

endmodule
`default_nettype wire

// File: cc_event_interrupt_regs_tb_top.sv
// Purpose: register-level checks of event mask, sticky status and attach fields
// Assumes: one strobe per two cycles, inputs driven 2 ns after the rising edge
// Notes: the host never writes offsets 14h to 17h
`timescale 1ns/1ps
`default_nettype none
module cc_event_interrupt_regs_tb_top;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	wire logic [7:0] reg_rdata;
	wire logic [7:0] attach_status;
	wire logic [7:0] event_mask;
	wire logic [7:0] event_status;
	wire logic irq;
	wire logic [1:0] det_rp_adv;
	wire logic [2:0] det_attach;
	wire logic [1:0] det_orient;
	int failures = 0;
	int total_checks = 0;
	logic [7:0] rsvd_tab [4] = '{8'h1F, 8'hC9, 8'h51, 8'h50};
	logic [7:0] v;
	cc_detector_model det (.det_rp_adv(det_rp_adv), .det_attach(det_attach), .det_orient(det_orient));
	cc_event_interrupt_regs dut (.ref_clk(ref_clk), .nrst(nrst), .det_rp_adv(det_rp_adv),
		.det_attach(det_attach), .det_orient(det_orient), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.attach_status(attach_status), .event_mask(event_mask), .event_status(event_status),
		.irq(irq));
	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// strobe lasts exactly one cycle; the leading edge wait keeps calls apart
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#2 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge ref_clk);
		#2 reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#2 {reg_addr, reg_rd} = {a, 1'b1};
		@(posedge ref_clk);
		#2 reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	// one event: masked keeps irq low, unmasking only bit b raises it, a read clears all
	task automatic ev(input logic [7:0] st, input int b, input logic [7:0] att);
		logic [7:0] r;
		repeat (20) @(posedge ref_clk);
		chk(attach_status, att);
		wr(8'h18, 8'h1F);
		chk({7'h00, irq}, 8'h00);
		wr(8'h18, 8'h1F & ~(8'h01 << b));
		chk(event_mask, 8'h1F & ~(8'h01 << b));
		chk({7'h00, irq}, 8'h01);
		chk(event_status, st);
		rd(8'h19, r);
		chk(r, st);
		chk(event_status, 8'h00);
		chk({7'h00, irq}, 8'h00);
		rd(8'h19, r);
		chk(r, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#20000;
		failures++;
		end_sim();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		#2 nrst = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h14 + 8'(i), v);
			chk(v, rsvd_tab[i]);
		end
		rd(8'h18, v);
		chk(v, 8'h1F);
		rd(8'h19, v);
		chk(v, 8'h00);
		chk({7'h00, irq}, 8'h00);
		rd(8'h30, v);
		chk(v, 8'h00);
		wr(8'h18, 8'hFF);
		rd(8'h18, v);
		chk(v, 8'h1F);
		wr(8'h19, 8'hFF);
		rd(8'h19, v);
		chk(v, 8'h00);
		det.drive(2'h0, 3'h4, 2'h0);
		ev(8'h0A, 1, 8'h10);
		det.drive(2'h0, 3'h4, 2'h1);
		ev(8'h04, 2, 8'h11);
		det.drive(2'h0, 3'h3, 2'h1);
		ev(8'h09, 0, 8'h0D);
		det.drive(2'h0, 3'h2, 2'h1);
		ev(8'h08, 3, 8'h09);
		det.drive(2'h2, 3'h2, 2'h1);
		ev(8'h10, 4, 8'h49);
		det.drive(2'h2, 3'h5, 2'h3);
		repeat (20) @(posedge ref_clk);
		chk(attach_status, 8'h49);
		rd(8'h19, v);
		chk(v, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire

// File: cc_event_pkg.sv
// Purpose: shared constants for the configuration-channel event mask and status registers
// Assumes: 8-bit register file reached through the internal register port of the serial slave
// Notes: offsets are the printed register offsets
package cc_event_pkg;
	// register offsets
	localparam logic [7:0] OFS_ATTACH = 8'h04;
	localparam logic [7:0] OFS_RSVD_A = 8'h14;
	localparam logic [7:0] OFS_RSVD_B = 8'h15;
	localparam logic [7:0] OFS_RSVD_C = 8'h16;
	localparam logic [7:0] OFS_RSVD_D = 8'h17;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h19;
	// fixed contents of the reserved registers
	localparam logic [7:0] RST_RSVD_A = 8'h1F;
	localparam logic [7:0] RST_RSVD_B = 8'hC9;
	localparam logic [7:0] RST_RSVD_C = 8'h51;
	localparam logic [7:0] RST_RSVD_D = 8'h50;
	// mask and status layout
	localparam logic [7:0] RST_MASK = 8'h1F;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_ATTACH = 8'h00;
	localparam int EV_WIDTH = 5;
	localparam int BIT_RP_CHANGE = 4;
	localparam int BIT_ROLE_CHANGE = 3;
	localparam int BIT_ORIENT_FOUND = 2;
	localparam int BIT_DEBUG_FOUND = 1;
	localparam int BIT_AUDIO_FOUND = 0;
	// attachment field codes
	localparam logic [2:0] ATT_NONE = 3'h0;
	localparam logic [2:0] ATT_SOURCE = 3'h1;
	localparam logic [2:0] ATT_SINK = 3'h2;
	localparam logic [2:0] ATT_AUDIO = 3'h3;
	localparam logic [2:0] ATT_DEBUG = 3'h4;
	// orientation codes
	localparam logic [1:0] ORI_NONE = 2'h0;
	localparam logic [1:0] ORI_NORMAL = 2'h1;
	localparam logic [1:0] ORI_REVERSED = 2'h2;
endpackage
